// >>> common/pvmr_pkg.sv
`default_nettype none
package pvmr_pkg;
  // register indices, as seen on the management interface
  localparam logic [4:0] IDX_POWER_DOWN_ENERGY_STATUS   = 5'h11;
  localparam logic [4:0] IDX_OPERATING_MODE_AND_ADDRESS = 5'h12;
  localparam logic [4:0] IDX_SYMBOL_ERROR_COUNT         = 5'h1A;
  localparam logic [4:0] IDX_CROSSOVER_POLARITY_CONTROL = 5'h1B;
  localparam logic [4:0] IDX_INTERRUPT_SOURCE_FLAGS     = 5'h1D;
  localparam logic [4:0] IDX_INTERRUPT_ENABLE_MASK      = 5'h1E;
  localparam logic [4:0] IDX_NEGOTIATION_SPEED_STATUS   = 5'h1F;

  // field positions
  localparam int POS_ENERGY_DETECT_POWERDOWN_ENABLE    = 13;
  localparam int POS_ENERGY_PRESENT = 1;
  localparam int POS_MODE_LSB       = 5;
  localparam int POS_ADDR_LSB       = 0;
  localparam int POS_XOVER_OVERRIDE = 15;
  localparam int POS_XOVER_AUTO     = 14;
  localparam int POS_XOVER_SWAP     = 13;
  localparam int POS_RX_POLARITY    = 4;
  localparam int POS_FLAG_LSB       = 1;
  localparam int POS_AN_DONE        = 12;
  localparam int POS_KEEP_LSB       = 5;
  localparam int POS_SPEED_LSB      = 2;

  // reset values
  localparam logic [2:0] RST_MODE           = 3'h7;
  localparam logic [4:0] RST_PORT_ADDRESS   = 5'h01;
  localparam logic [6:0] RST_KEEP_PATTERN   = 7'h02;
  localparam logic [6:0] RST_MASK           = 7'h00;
  localparam logic [15:0] RST_SYMBOL_COUNT  = 16'h0000;

  // timing
  localparam int CLK_MHZ        = 250;
  localparam int ENERGY_LOSS_MS = 256;
  localparam longint ENERGY_LOSS_CYCLES = longint'(ENERGY_LOSS_MS) * 1000 * CLK_MHZ;

  typedef enum logic [2:0] {
    MODE_10_HALF, MODE_10_FULL, MODE_100_HALF, MODE_100_FULL,
    MODE_AN_100_HALF, MODE_REPEATER, MODE_RESERVED, MODE_ALL_CAPABLE
  } pvmr_mode_e;

  // register access from the management engine
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [4:0] phy_addr;
    logic [4:0] reg_idx;
    logic [15:0] wdata;
  } pvmr_req_s;

  // events from the PHY core, one-cycle pulses except levels noted
  typedef struct packed {
    logic energy_valid;       // level: valid line energy seen
    logic symbol_error;       // pulse
    logic packet_end;         // pulse
    logic rx_polarity_rev;    // level
    logic negotiation_done;   // level
    logic [2:0] speed_duplex; // level
    logic [7:1] flag_events;  // pulses
  } pvmr_core_s;

  // controls handed back to the PHY core
  typedef struct packed {
    logic       energy_detect_powerdown;
    logic [2:0] operating_mode;
    logic       autoneg_enable;
    logic       speed_100;
    logic       full_duplex;
    logic [3:0] advertise;
    logic       crs_on_transmit;
    logic       repeater;
    logic       crossover_auto;
    logic       crossover_swap;
  } pvmr_ctrl_s;
endpackage
`default_nettype wire

// >>> logic/pvmr_regs.sv
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// [R1] bit 13 enables energy-detect power-down
// [R2] software should enable negotiation before power-down
// [R3] energy bit drops after 256 ms silence
// [R4] mode field 7:5, default 111, soft-kept
// [R5] codes 000/001 force 10 Mbps half/full
// [R6] codes 010/011 force 100 Mbps half/full
// [R7] codes 100/101 negotiate, advertise 100 half
// [R8] code 111 negotiates, advertises all abilities
// [R9] software never writes mode code 110
// [R10] address field 4:0, default 00001, soft-kept
// [R11] bad-symbol counter, once per packet
// [R12] bad-symbol counter wraps past maximum
// [R13] counter cleared by reset, frozen in 10 Mbps
// [R14] bit 15 overrides the crossover strap
// [R15] bit 14 chooses automatic crossover when overridden
// [R16] bit 13 swaps pairs in manual crossover
// [R17] software never sets bits 15,14,13 together
// [R18] bit 4 shows 10 Mbps receive polarity
// [R19] latched interrupt flags in bits 7:1
// [R20] mask bits 7:1 enable flags, reset zero
// [R21] bit 12 shows negotiation done
// [R22] bits 11:5 hold 0000010 pattern
// [R23] bits 4:2 report resolved speed and duplex
// [R24] interrupt request follows masked flags
module pvmr_regs
  import pvmr_pkg::*;
#(
  parameter longint ENERGY_LOSS_COUNT = pvmr_pkg::ENERGY_LOSS_CYCLES
) (
  input  wire logic               clk,           // 250 MHz core clock
  input  wire logic               nrst,          // hardware reset, active low
  input  wire logic               soft_rst,      // software reset pulse
  input  wire pvmr_pkg::pvmr_req_s req,          // register access request
  input  wire pvmr_pkg::pvmr_core_s core,        // status from PHY core
  input  wire logic               xover_strap,   // crossover_auto_strap pin
  output logic [15:0]             rdata,         // read data, valid after rd
  output logic                    rvalid,        // read data valid pulse
  output pvmr_pkg::pvmr_ctrl_s    ctrl,          // controls to PHY core
  output logic                    irq            // interrupt request, active high
);
  import pvmr_pkg::*;

  localparam int ECW = 34;

  logic        energy_detect_powerdown_q;
  logic        energy_present_q;
  logic [ECW-1:0] silence_q;
  logic [2:0]  mode_q;
  logic [4:0]  addr_q;
  logic [15:0] bad_symbol_count_q;
  logic        pkt_err_seen_q;
  logic        x_override_q;
  logic        x_auto_q;
  logic        x_swap_q;
  logic [7:1]  flags_q;
  logic [7:1]  mask_q;
  logic [6:0]  keep_q;
  logic        strap_s1_q;
  logic        strap_s2_q;
  logic        strap_q;
  logic        strap_taken_q;
  logic [1:0]  strap_wait_q;
  logic        pol_s1_q;
  logic        pol_s2_q;
  logic        en_s1_q;
  logic        en_s2_q;
  logic        energy_prev_q;

  // core status arrives from the analogue side, so synchronise the polarity and energy levels
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pol_s1_q <= 1'b0;
      pol_s2_q <= 1'b0;
      en_s1_q  <= 1'b0;
      en_s2_q  <= 1'b0;
    end else begin
      pol_s1_q <= core.rx_polarity_rev;
      pol_s2_q <= pol_s1_q;
      en_s1_q  <= core.energy_valid;
      en_s2_q  <= en_s1_q;
    end
  end

  // strap is captured once after reset release, through a synchroniser
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      strap_s1_q    <= 1'b0;
      strap_s2_q    <= 1'b0;
      strap_q       <= 1'b0;
      strap_taken_q <= 1'b0;
      strap_wait_q  <= 2'h0;
    end else begin
      strap_s1_q <= xover_strap;
      strap_s2_q <= strap_s1_q;
      if (!strap_taken_q) begin
        // wait until the pin has reached the second stage, else the reset value is taken
        if (strap_wait_q == 2'h2) begin
          strap_q       <= strap_s2_q;
          strap_taken_q <= 1'b1;
        end else begin
          strap_wait_q <= strap_wait_q + 2'h1;
        end
      end
    end
  end

  logic addr_hit;
  logic wr_hit;
  assign addr_hit = (req.phy_addr == addr_q);
  assign wr_hit   = req.wr && addr_hit;

  function automatic logic wr_to(input logic [4:0] idx);
    return wr_hit && (req.reg_idx == idx);
  endfunction

  // power-down enable is soft-resettable
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      energy_detect_powerdown_q <= 1'b0;
    end else if (soft_rst) begin
      energy_detect_powerdown_q <= 1'b0;
    end else if (wr_to(IDX_POWER_DOWN_ENERGY_STATUS)) begin
      energy_detect_powerdown_q <= req.wdata[POS_ENERGY_DETECT_POWERDOWN_ENABLE]; // see [R1]
    end
  end

  // energy status: set by hardware reset and by valid line energy
  // the silence counter holds at its limit instead of wrapping, so a long
  // quiet line never brings the bit back by itself
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      energy_present_q <= 1'b1;
      silence_q        <= '0;
      energy_prev_q    <= 1'b1;
    end else begin
      energy_prev_q <= energy_present_q;
      if (en_s2_q) begin
        silence_q        <= '0;
        energy_present_q <= 1'b1;
      end else if (silence_q >= ECW'(ENERGY_LOSS_COUNT - 1)) begin
        energy_present_q <= 1'b0; // see [R3]
      end else begin
        silence_q <= silence_q + ECW'(1);
      end
    end
  end

  // mode and address survive software reset
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      mode_q <= RST_MODE;
      addr_q <= RST_PORT_ADDRESS;
    end else if (wr_to(IDX_OPERATING_MODE_AND_ADDRESS)) begin
      mode_q <= req.wdata[POS_MODE_LSB +: 3];  // see [R4]
      addr_q <= req.wdata[POS_ADDR_LSB +: 5];  // see [R10]
    end
  end

  // one count per packet regardless of how many bad symbols it holds
  // the resolved-speed field also blocks counting, since a negotiated
  // 10 Mbps link runs with the all-capable mode code
  logic mode_is_10;
  assign mode_is_10 = (mode_q == MODE_10_HALF) || (mode_q == MODE_10_FULL) ||
                      (core.speed_duplex[1:0] == 2'h1);
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      bad_symbol_count_q <= RST_SYMBOL_COUNT;
      pkt_err_seen_q     <= 1'b0;
    end else if (soft_rst) begin
      bad_symbol_count_q <= RST_SYMBOL_COUNT; // see [R13]
      pkt_err_seen_q     <= 1'b0;
    end else begin
      if (core.symbol_error && !pkt_err_seen_q && !mode_is_10) begin // see [R11] [R13]
        bad_symbol_count_q <= bad_symbol_count_q + 16'h0001; // see [R12]
      end
      if (core.packet_end) begin
        pkt_err_seen_q <= 1'b0;
      end else if (core.symbol_error) begin
        pkt_err_seen_q <= 1'b1;
      end
    end
  end

  // crossover control, soft-kept
  // swap is masked later under automatic crossover so a stray bit cannot reverse pairs
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      x_override_q <= 1'b0;
      x_auto_q     <= 1'b0;
      x_swap_q     <= 1'b0;
    end else if (wr_to(IDX_CROSSOVER_POLARITY_CONTROL)) begin
      x_override_q <= req.wdata[POS_XOVER_OVERRIDE]; // see [R14]
      x_auto_q     <= req.wdata[POS_XOVER_AUTO];
      x_swap_q     <= req.wdata[POS_XOVER_SWAP];
    end
  end

  // latched flags clear on read; a new event in the read cycle wins
  logic rd_flags;
  assign rd_flags = req.rd && addr_hit && (req.reg_idx == IDX_INTERRUPT_SOURCE_FLAGS);
  logic [7:1] events;
  assign events = {core.flag_events[7:1] | {~energy_prev_q & energy_present_q, 6'h00}};
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      flags_q <= 7'h00;
    end else if (soft_rst) begin
      flags_q <= 7'h00;
    end else begin
      flags_q <= (rd_flags ? 7'h00 : flags_q) | events; // see [R19]
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      mask_q <= RST_MASK;
    end else if (soft_rst) begin
      mask_q <= RST_MASK;
    end else if (wr_to(IDX_INTERRUPT_ENABLE_MASK)) begin
      mask_q <= req.wdata[POS_FLAG_LSB +: 7]; // see [R20]
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      keep_q <= RST_KEEP_PATTERN;
    end else if (soft_rst) begin
      keep_q <= RST_KEEP_PATTERN;
    end else if (wr_to(IDX_NEGOTIATION_SPEED_STATUS)) begin
      keep_q <= req.wdata[POS_KEEP_LSB +: 7]; // see [R22]
    end
  end

  // interrupt request from the stored flags and mask
  // registered so the pin cannot glitch while flags and mask
  // change in the same cycle
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(flags_q & mask_q); // see [R24]
    end
  end

  // read mux
  // unmapped indices read as zero but still answer, so a master
  // that probes the map never stalls
  logic [15:0] rd_word;
  always_comb begin
    rd_word = 16'h0000;
    case (req.reg_idx)
      IDX_POWER_DOWN_ENERGY_STATUS: begin
        rd_word[POS_ENERGY_DETECT_POWERDOWN_ENABLE]    = energy_detect_powerdown_q;
        rd_word[POS_ENERGY_PRESENT] = energy_present_q;
      end
      IDX_OPERATING_MODE_AND_ADDRESS: begin
        rd_word[POS_MODE_LSB +: 3] = mode_q;
        rd_word[POS_ADDR_LSB +: 5] = addr_q;
      end
      IDX_SYMBOL_ERROR_COUNT: rd_word = bad_symbol_count_q; // see [R13]
      IDX_CROSSOVER_POLARITY_CONTROL: begin
        rd_word[POS_XOVER_OVERRIDE] = x_override_q;
        rd_word[POS_XOVER_AUTO]     = x_auto_q;
        rd_word[POS_XOVER_SWAP]     = x_swap_q;
        rd_word[POS_RX_POLARITY]    = pol_s2_q; // see [R18]
      end
      IDX_INTERRUPT_SOURCE_FLAGS: rd_word[POS_FLAG_LSB +: 7] = flags_q;
      IDX_INTERRUPT_ENABLE_MASK:  rd_word[POS_FLAG_LSB +: 7] = mask_q;
      IDX_NEGOTIATION_SPEED_STATUS: begin
        rd_word[POS_AN_DONE]        = core.negotiation_done && ctrl.autoneg_enable; // see [R21]
        rd_word[POS_KEEP_LSB +: 7]  = keep_q;
        rd_word[POS_SPEED_LSB +: 3] = core.speed_duplex; // see [R23]
      end
      default: rd_word = 16'h0000;
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rdata  <= 16'h0000;
      rvalid <= 1'b0;
    end else begin
      rvalid <= req.rd && addr_hit;
      if (req.rd && addr_hit) begin
        rdata <= rd_word;
      end
    end
  end

  // decode the operating mode into core controls
  pvmr_ctrl_s ctrl_d;
  always_comb begin
    ctrl_d                         = '0;
    ctrl_d.energy_detect_powerdown = energy_detect_powerdown_q; // see [R1]
    ctrl_d.operating_mode          = mode_q;
    case (mode_q)
      MODE_10_HALF: ctrl_d.crs_on_transmit = 1'b1; // see [R5]
      MODE_10_FULL: ctrl_d.full_duplex     = 1'b1; // see [R5]
      MODE_100_HALF: begin // see [R6]
        ctrl_d.speed_100       = 1'b1;
        ctrl_d.crs_on_transmit = 1'b1;
      end
      MODE_100_FULL: begin // see [R6]
        ctrl_d.speed_100   = 1'b1;
        ctrl_d.full_duplex = 1'b1;
      end
      MODE_AN_100_HALF, MODE_REPEATER: begin // see [R7]
        ctrl_d.speed_100       = 1'b1;
        ctrl_d.autoneg_enable  = 1'b1;
        ctrl_d.advertise       = 4'h4;
        ctrl_d.crs_on_transmit = (mode_q == MODE_AN_100_HALF);
        ctrl_d.repeater        = (mode_q == MODE_REPEATER);
      end
      MODE_ALL_CAPABLE: begin // see [R8]
        ctrl_d.speed_100       = 1'b1;
        ctrl_d.autoneg_enable  = 1'b1;
        ctrl_d.advertise       = 4'hF;
        ctrl_d.crs_on_transmit = 1'b1;
      end
      // reserved code: left as all-off, software is not to use it
      default: ctrl_d.operating_mode = mode_q;
    endcase
    if (x_override_q) begin
      ctrl_d.crossover_auto = x_auto_q;                  // see [R15]
      ctrl_d.crossover_swap = !x_auto_q && x_swap_q;     // see [R16]
    end else begin
      ctrl_d.crossover_auto = strap_q;                   // see [R14]
    end
  end

  // registered so every control reaches the core one cycle after the register that drives it, two cycles after a write
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ctrl <= '0;
    end else begin
      ctrl <= ctrl_d;
    end
  end
endmodule
`default_nettype wire

// >>> tb/pvmr_regs_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module pvmr_regs_asserts
  import pvmr_pkg::*;
(
  input wire logic                 clk,      // core clock
  input wire logic                 nrst,     // hardware reset
  input wire logic                 soft_rst, // software reset
  input wire pvmr_pkg::pvmr_req_s  req,      // request
  input wire logic                 rvalid,   // read strobe
  input wire pvmr_pkg::pvmr_ctrl_s ctrl,     // controls
  input wire logic                 irq       // interrupt
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  wire logic [2:0] m = ctrl.operating_mode;
  wire logic flag_clear = (req.rd && req.reg_idx == IDX_INTERRUPT_SOURCE_FLAGS) || req.wr || soft_rst;
  wire logic mode_write = req.wr && req.reg_idx == IDX_OPERATING_MODE_AND_ADDRESS;
  a_read_answer_source: assert property (rvalid |-> $past(req.rd)) else $error("read answer without read");
  a_mode_forced_decode: assert property (m < 3'h4 |-> !ctrl.autoneg_enable && ctrl.speed_100 == m[1]
    && ctrl.full_duplex == m[0]) else $error("forced mode decode wrong");
  a_mode_negotiate_100: assert property (m[2:1] == 2'h2 |-> ctrl.autoneg_enable && ctrl.advertise == 4'h4
    && ctrl.speed_100 && !ctrl.full_duplex && ctrl.repeater == m[0]) else $error("100 advertise decode wrong");
  a_crs_on_transmit: assert property (m inside {3'h2, 3'h3, 3'h4, 3'h5} |-> ctrl.crs_on_transmit == !m[0])
    else $error("carrier sense mode wrong");
  a_mode_all_capable: assert property (m == 3'h7 |-> ctrl.autoneg_enable && ctrl.advertise == 4'hF
    && ctrl.speed_100) else $error("all capable decode wrong");
  a_swap_when_auto: assert property (ctrl.crossover_auto |-> !ctrl.crossover_swap)
    else $error("swap set under auto crossover");
  a_mode_soft_kept: assert property ($changed(m) && $past(nrst, 2) |-> $past(mode_write, 2))
    else $error("mode changed without write");
  a_energy_detect_powerdown_write_only: assert property ($changed(ctrl.energy_detect_powerdown) |-> $past(req.wr, 2)
    || $past(soft_rst, 2)) else $error("power down changed without cause");
  a_irq_drop_cause: assert property ($fell(irq) |-> $past(flag_clear, 2))
    else $error("interrupt dropped without cause");
endmodule
bind pvmr_regs pvmr_regs_asserts u_pvmr_regs_asserts (.clk(clk), .nrst(nrst), .soft_rst(soft_rst), .req(req),
  .rvalid(rvalid), .ctrl(ctrl), .irq(irq));
`default_nettype wire

// >>> tb/pvmr_mgmt_model.sv
`timescale 1ns/1ps
`default_nettype none
module pvmr_mgmt_model
  import pvmr_pkg::*;
(
  input  wire logic                clk,    // core clock
  input  wire logic                rvalid, // read answer strobe
  input  wire logic [15:0]         rdata,  // read answer
  output var pvmr_pkg::pvmr_req_s  req     // request to the registers
);
  initial req = '0;
  // idle fields are inverted so a stale request never looks like a fresh one
  task automatic xfer(input logic w, input logic [4:0] a, input logic [4:0] i, input logic [15:0] d,
                      output logic [15:0] q, output logic ok);
    if (w && i == IDX_NEGOTIATION_SPEED_STATUS) d[11:5] = RST_KEEP_PATTERN;
    if (w && i == IDX_OPERATING_MODE_AND_ADDRESS && d[7:5] == 3'h6) d[7:5] = 3'h7;
    if (w && i == IDX_CROSSOVER_POLARITY_CONTROL && d[14]) d[13] = 1'b0;
    q = 16'h0000;
    ok = w;
    @(posedge clk);
    req <= '{wr: w, rd: !w, phy_addr: a, reg_idx: i, wdata: d};
    @(posedge clk);
    req <= '{wr: 1'b0, rd: 1'b0, phy_addr: ~a, reg_idx: ~i, wdata: ~d};
    for (int n = 0; n < 3 && !ok; n++) begin
      #1;
      if (rvalid) begin
        ok = 1'b1;
        q = rdata;
      end else @(posedge clk);
    end
  endtask
endmodule
`default_nettype wire

// >>> tb/test_phy_vendor_mgmt_registers.sv
`timescale 1ns/1ps
`default_nettype none
module test_phy_vendor_mgmt_registers;
  import pvmr_pkg::*;
  logic clk = 0, nrst = 0, soft_rst = 0, xover_strap = 1, rvalid, irq, ok;
  pvmr_core_s core = '0;
  pvmr_req_s  req;
  pvmr_ctrl_s ctrl;
  logic [15:0] rdata, q;
  logic [4:0]  adr = 5'h01;
  logic [2:0]  sd[4] = '{3'h1, 3'h5, 3'h2, 3'h6};
  logic [15:0] xw[4] = '{16'h0000, 16'h8000, 16'hA000, 16'hC000};
  logic [1:0]  xe[4] = '{2'h2, 2'h0, 2'h1, 2'h2};
  int errors = 0, n_compared = 0, cnt, k;
  always #2 clk = ~clk;
  pvmr_regs #(.ENERGY_LOSS_COUNT(16)) u_pvmr_regs (.clk(clk), .nrst(nrst), .soft_rst(soft_rst), .req(req),
    .core(core), .xover_strap(xover_strap), .rdata(rdata), .rvalid(rvalid), .ctrl(ctrl), .irq(irq));
  pvmr_mgmt_model mgmt (.clk(clk), .rvalid(rvalid), .rdata(rdata), .req(req));
  task stop_test;
    $display("compared %0d, errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task chk(input logic [15:0] g, input logic [15:0] e);
    n_compared++;
    if (g !== e) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task rd(input logic [4:0] i);
    mgmt.xfer(1'b0, adr, i, 16'h0000, q, ok);
    if (ok !== 1'b1) begin
      errors++;
      $display("Error at %0t: no read answer", $time);
      stop_test;
    end
  endtask
  task wr(input logic [4:0] i, input logic [15:0] d);
    mgmt.xfer(1'b1, adr, i, d, q, ok);
    repeat (2) @(posedge clk);
    #1;
  endtask
  task pkt(input int n);
    repeat (n) @(posedge clk) core.symbol_error <= 1'b1;
    @(posedge clk) core.symbol_error <= 1'b0;
    core.packet_end <= 1'b1;
    @(posedge clk) core.packet_end <= 1'b0;
  endtask
  task flag(input int b);
    @(posedge clk) core.flag_events[b] <= 1'b1;
    @(posedge clk) core.flag_events <= '0;
    repeat (2) @(posedge clk);
    #1;
  endtask
  initial begin
    repeat (100000) @(posedge clk);
    errors++;
    $display("Error at %0t: run limit reached", $time);
    stop_test;
  end
  initial begin
    core.energy_valid = 1'b1;
    void'($urandom(70981));
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    repeat (6) @(posedge clk);
    rd(IDX_OPERATING_MODE_AND_ADDRESS); chk(q, 16'h00E1);
    rd(IDX_POWER_DOWN_ENERGY_STATUS); chk(q, 16'h0002);
    rd(IDX_SYMBOL_ERROR_COUNT); chk(q, 16'h0000);
    rd(IDX_INTERRUPT_ENABLE_MASK); chk(q, 16'h0000);
    for (k = 0; k < 4; k++) begin
      @(posedge clk) core.speed_duplex <= sd[k];
      core.negotiation_done <= k[0];
      rd(IDX_NEGOTIATION_SPEED_STATUS); chk(q, {3'h0, k[0], 7'h02, sd[k], 2'h0});
    end
    $display("test defaults done");
    for (k = 0; k < 8; k++) if (k != 6) begin
      wr(IDX_OPERATING_MODE_AND_ADDRESS, {8'h00, k[2:0], adr});
      chk({12'h0, ctrl.operating_mode, ctrl.autoneg_enable}, {12'h0, k[2:0], k[2]});
    end
    wr(IDX_POWER_DOWN_ENERGY_STATUS, 16'h2000);
    rd(IDX_POWER_DOWN_ENERGY_STATUS); chk(q, 16'h2002);
    chk({15'h0, ctrl.energy_detect_powerdown}, 16'h0001);
    wr(IDX_POWER_DOWN_ENERGY_STATUS, 16'h0000);
    $display("test modes done");
    @(posedge clk) core.speed_duplex <= 3'h6;
    cnt = 0;
    for (int p = 0; p < 20; p++) begin
      k = $urandom_range(3, 0);
      cnt += (k != 0);
      pkt(k);
    end
    rd(IDX_SYMBOL_ERROR_COUNT); chk(q, 16'(cnt));
    wr(IDX_OPERATING_MODE_AND_ADDRESS, {8'h00, 3'h0, adr});
    core.speed_duplex <= 3'h1;
    pkt(2);
    rd(IDX_SYMBOL_ERROR_COUNT); chk(q, 16'(cnt));
    wr(IDX_OPERATING_MODE_AND_ADDRESS, {8'h00, 3'h7, adr});
    $display("test symbol count done");
    for (k = 0; k < 4; k++) begin
      wr(IDX_CROSSOVER_POLARITY_CONTROL, xw[k]);
      chk({14'h0, ctrl.crossover_auto, ctrl.crossover_swap}, {14'h0, xe[k]});
    end
    @(posedge clk) core.rx_polarity_rev <= 1'b1;
    repeat (4) @(posedge clk);
    rd(IDX_CROSSOVER_POLARITY_CONTROL); chk(q, 16'hC010);
    $display("test crossover done");
    wr(IDX_INTERRUPT_ENABLE_MASK, 16'h00FE);
    k = $urandom_range(7, 1);
    flag(k);
    chk({15'h0, irq}, 16'h0001);
    rd(IDX_INTERRUPT_SOURCE_FLAGS); chk(q, 16'h0001 << k);
    repeat (3) @(posedge clk);
    #1 chk({15'h0, irq}, 16'h0000);
    wr(IDX_INTERRUPT_ENABLE_MASK, 16'h0000);
    flag(k);
    chk({15'h0, irq}, 16'h0000);
    rd(IDX_INTERRUPT_SOURCE_FLAGS); chk(q, 16'h0001 << k);
    $display("test interrupts done");
    mgmt.xfer(1'b0, 5'h02, IDX_OPERATING_MODE_AND_ADDRESS, 16'h0000, q, ok);
    chk({15'h0, ok}, 16'h0000);
    wr(IDX_OPERATING_MODE_AND_ADDRESS, 16'h00E3);
    adr = 5'h03;
    wr(IDX_INTERRUPT_ENABLE_MASK, 16'h0004);
    @(posedge clk) soft_rst <= 1'b1;
    @(posedge clk) soft_rst <= 1'b0;
    rd(IDX_OPERATING_MODE_AND_ADDRESS); chk(q, 16'h00E3);
    rd(IDX_INTERRUPT_ENABLE_MASK); chk(q, 16'h0000);
    $display("test address and soft reset done");
    @(posedge clk) core.energy_valid <= 1'b0;
    repeat (40) @(posedge clk);
    rd(IDX_POWER_DOWN_ENERGY_STATUS); chk(q, 16'h0000);
    @(posedge clk) soft_rst <= 1'b1;
    @(posedge clk) soft_rst <= 1'b0;
    rd(IDX_POWER_DOWN_ENERGY_STATUS); chk(q, 16'h0000);
    @(posedge clk) core.energy_valid <= 1'b1;
    repeat (8) @(posedge clk);
    rd(IDX_POWER_DOWN_ENERGY_STATUS); chk(q, 16'h0002);
    rd(IDX_INTERRUPT_SOURCE_FLAGS); chk(q, 16'h0080);
    $display("test energy done");
    stop_test;
  end
endmodule
`default_nettype wire
